// ### design/icf_pkg.sv
// constants and types shared by the instruction fetch pointer and cache
package icf_pkg;
	// address geometry: bit addresses, 16-bit words, 64-byte segments
	localparam int ADDR_W      = 32;
	localparam int WORD_W      = 16;
	localparam int SEG_N       = 4;
	localparam int SUB_N       = 8;
	localparam int SUB_WORDS   = 4;
	localparam int TAG_W       = 23;
	localparam int TAG_LSB     = 9;
	localparam int SUB_LSB     = 6;
	localparam int SUB_W       = 3;
	localparam int WORD_LSB    = 4;
	localparam int WIDX_W      = 2;
	localparam int SEG_W       = 2;
	localparam int ALIGN_W     = 4;
	localparam int ENTRY_N     = SEG_N * SUB_N * SUB_WORDS;
	localparam int ENTRY_W     = SEG_W + SUB_W + WIDX_W;

	// reset values and pointer step
	localparam logic [ADDR_W-1:0]  PTR_RESET  = 32'h0000_0000;
	localparam logic [ADDR_W-1:0]  PTR_STEP   = 32'h0000_0010;
	localparam logic [ALIGN_W-1:0] ALIGN_ZERO = 4'h0;
	localparam logic [SUB_LSB-1:0] SUB_OFS_0  = 6'h00;
	localparam logic [WIDX_W-1:0]  WIDX_LAST  = 2'h3;

	typedef logic [SEG_N-1:0][SEG_W-1:0] icf_lru_t;
	typedef logic [SEG_N-1:0][TAG_W-1:0] icf_tags_t;
	typedef logic [SEG_N-1:0][SUB_N-1:0] icf_pres_t;

	// lru stack order after reset: entry 0 most recent, entry 3 the victim
	localparam icf_lru_t LRU_RESET = {2'h3, 2'h2, 2'h1, 2'h0};

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_FILL
	} icf_state_t;
endpackage

// ### design/icf_fetch.sv
// instruction fetch pointer with four-segment lru instruction cache
// How it works
// (RQ1) a 32-bit fetch pointer holds the bit address of the next instruction word to fetch.
// (RQ2) the low four pointer bits are forced to zero on every load and step.
// (RQ3) the cache stores 256 bytes as four segments of 64 bytes.
// (RQ4) every segment keeps a 23-bit tag naming the memory region it holds.
// (RQ5) each segment is eight subsegments of four words each.
// (RQ6) a hit needs a matching tag and a set present flag for the subsegment.
// (RQ7) memory is asked for words only on a miss, never on a hit.
// (RQ8) a new segment is always taken from the least recently used one.
// (RQ9) a four by two stack keeps the order in which segments were used.
// (RQ10) lookup, loading and replacement run by themselves and return correct words.
// (RQ11) a flush request from the host control function invalidates the cache.
// (RQ12) a tag miss retags the victim, clears its flags and loads one subsegment.
// (RQ13) a flush clears every present flag; tags compare pointer bits above the segment.
`timescale 1ns/1ps
module icf_fetch
	import icf_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              fetch_req_i,
	output logic                   fetch_ready_o,
	output logic                   fetch_valid_o,
	output logic [WORD_W-1:0]      fetch_word_o,
	input  wire logic              ptr_load_i,
	input  wire logic [ADDR_W-1:0] ptr_load_addr_i,
	output logic [ADDR_W-1:0]      instruction_fetch_pointer_o,
	input  wire logic              flush_i,
	output logic                   mem_req_o,
	output logic [ADDR_W-1:0]      mem_addr_o,
	input  wire logic              mem_valid_i,
	input  wire logic [WORD_W-1:0] mem_data_i
);

	// address field helpers, shared by lookup and fill
	function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:TAG_LSB]; // RQ13
	endfunction

	function automatic logic [SUB_W-1:0] sub_of(input logic [ADDR_W-1:0] a);
		return a[TAG_LSB-1:SUB_LSB];
	endfunction

	function automatic logic [WIDX_W-1:0] widx_of(input logic [ADDR_W-1:0] a);
		return a[SUB_LSB-1:WORD_LSB];
	endfunction

	// move a segment to the top of the usage stack, keeping the others in order
	function automatic icf_lru_t touch(input icf_lru_t s, input logic [SEG_W-1:0] seg);
		icf_lru_t   r;
		logic [2:0] j;
		r    = s;
		j    = 3'h1;
		r[0] = seg;
		for (int i = 0; i < SEG_N; i++) begin
			if (s[i] != seg && j < 3'h4) begin
				r[j[1:0]] = s[i];
				j         = j + 3'h1;
			end
		end
		return r;
	endfunction

	// state
	icf_state_t              state_q, state_d;
	logic [ADDR_W-1:0]       ptr_q, ptr_d;
	icf_tags_t               tag_q, tag_d;
	icf_pres_t               pres_q, pres_d;
	icf_lru_t                lru_q, lru_d;
	logic [SEG_W-1:0]        fseg_q, fseg_d;
	logic [SUB_W-1:0]        fsub_q, fsub_d;
	logic [ADDR_W-1:0]       faddr_q, faddr_d;
	logic [WIDX_W-1:0]       fcnt_q, fcnt_d;
	logic                    fkill_q, fkill_d;
	logic                    valid_q, valid_d;
	logic [WORD_W-1:0]       word_q, word_d;
	logic [WORD_W-1:0]       store [ENTRY_N]; // RQ3

	// lookup signals
	logic [TAG_W-1:0]        cur_tag;
	logic [SUB_W-1:0]        cur_sub;
	logic                    tag_hit;
	logic [SEG_W-1:0]        hit_seg;
	logic                    hit;
	logic [SEG_W-1:0]        victim;
	logic [WORD_W-1:0]       rd_word;
	logic                    take;
	logic                    miss_go;
	logic                    fill_end;
	logic                    wr_en;
	logic [ENTRY_W-1:0]      wr_idx;

	// tag compare across all segments; reset leaves equal tags, but the
	// highest match wins and only that segment is ever filled, so no clash
	always_comb begin
		cur_tag = tag_of(ptr_q);
		cur_sub = sub_of(ptr_q);
		tag_hit = 1'b0;
		hit_seg = '0;
		for (int s = 0; s < SEG_N; s++) begin
			if (tag_q[s] == cur_tag) begin
				tag_hit = 1'b1;
				hit_seg = SEG_W'(s);
			end
		end
		hit     = tag_hit && pres_q[hit_seg][cur_sub]; // RQ6
		victim  = lru_q[SEG_N-1]; // RQ8
		rd_word = store[{hit_seg, cur_sub, widx_of(ptr_q)}];
	end

	assign fetch_ready_o = (state_q == ST_IDLE) && hit;
	assign take          = fetch_req_i && fetch_ready_o;
	// a pointer load in the same cycle cancels the miss, it names a new target
	assign miss_go       = (state_q == ST_IDLE) && fetch_req_i && !hit && !ptr_load_i;
	assign fill_end      = (state_q == ST_FILL) && mem_valid_i && (fcnt_q == WIDX_LAST);
	assign mem_req_o     = (state_q == ST_FILL); // RQ7
	assign mem_addr_o    = faddr_q;
	assign wr_en         = (state_q == ST_FILL) && mem_valid_i;
	assign wr_idx        = {fseg_q, fsub_q, fcnt_q};

	assign instruction_fetch_pointer_o = ptr_q;
	assign fetch_valid_o               = valid_q;
	assign fetch_word_o                = word_q;

	// fetch pointer: load wins over the step of a word taken in the same cycle
	always_comb begin
		ptr_d = ptr_q;
		if (ptr_load_i) begin
			ptr_d = {ptr_load_addr_i[ADDR_W-1:ALIGN_W], ALIGN_ZERO}; // RQ2
		end else if (take) begin
			ptr_d = ptr_q + PTR_STEP; // RQ1
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_q <= PTR_RESET;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	// hit delivery: word and valid come from flops, one cycle after take
	always_comb begin
		valid_d = take; // RQ10
		word_d  = take ? rd_word : word_q;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_q <= 1'b0;
			word_q  <= '0;
		end else begin
			valid_q <= valid_d;
			word_q  <= word_d;
		end
	end

	// cache control: tags, present flags, lru stack and fill sequencing
	always_comb begin
		state_d = state_q;
		tag_d   = tag_q;
		pres_d  = pres_q;
		lru_d   = lru_q;
		fseg_d  = fseg_q;
		fsub_d  = fsub_q;
		faddr_d = faddr_q;
		fcnt_d  = fcnt_q;
		fkill_d = fkill_q;
		unique case (state_q)
			ST_IDLE: begin
				if (take) begin
					lru_d = touch(lru_q, hit_seg); // RQ9
				end else if (miss_go) begin
					state_d = ST_FILL;
					fcnt_d  = '0;
					fkill_d = 1'b0;
					fsub_d  = cur_sub;
					faddr_d = {cur_tag, cur_sub, SUB_OFS_0};
					if (tag_hit) begin
						fseg_d = hit_seg; // RQ12
					end else begin
						fseg_d         = victim; // RQ8
						tag_d[victim]  = cur_tag; // RQ4
						pres_d[victim] = '0; // RQ12
					end
				end
			end
			ST_FILL: begin
				if (mem_valid_i) begin
					fcnt_d = fcnt_q + 2'h1;
				end
				if (fill_end) begin
					state_d = ST_IDLE;
					lru_d   = touch(lru_q, fseg_q); // RQ9
					if (!fkill_q && !flush_i) begin
						pres_d[fseg_q][fsub_q] = 1'b1; // RQ5
					end
				end
			end
		endcase
		// a flush mid-fill also kills the line being loaded, since its words
		// may have been fetched before the host changed memory
		if (flush_i) begin
			pres_d  = '0; // RQ11 RQ13
			fkill_d = (state_d == ST_FILL);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			tag_q   <= '0;
			pres_q  <= '0;
			lru_q   <= LRU_RESET;
			fseg_q  <= '0;
			fsub_q  <= '0;
			faddr_q <= '0;
			fcnt_q  <= '0;
			fkill_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tag_q   <= tag_d;
			pres_q  <= pres_d;
			lru_q   <= lru_d;
			fseg_q  <= fseg_d;
			fsub_q  <= fsub_d;
			faddr_q <= faddr_d;
			fcnt_q  <= fcnt_d;
			fkill_q <= fkill_d;
		end
	end

	// word storage has no reset; present flags guard every read
	always_ff @(posedge mclk_i) begin
		if (wr_en) begin
			store[wr_idx] <= mem_data_i; // RQ3
		end
	end

	// checks
	a_ptr_align: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ2
		ptr_q[ALIGN_W-1:0] == ALIGN_ZERO)
		else $error("fetch pointer low bits not zero");

	a_ptr_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ1
		take && !ptr_load_i |=> ptr_q == $past(ptr_q) + PTR_STEP)
		else $error("fetch pointer did not step one word");

	a_hit_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ7
		take |=> !mem_req_o)
		else $error("memory requested after a hit");

	a_miss_fill: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ7
		miss_go |=> mem_req_o && mem_addr_o == {$past(cur_tag), $past(cur_sub), SUB_OFS_0})
		else $error("miss did not request its subsegment");

	a_hit_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ6
		fetch_ready_o |-> tag_q[hit_seg] == tag_of(ptr_q) && pres_q[hit_seg][cur_sub])
		else $error("hit without tag and present flag");

	a_alloc_lru: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ8
		miss_go && !tag_hit |=> tag_q[$past(victim)] == $past(cur_tag)
			&& pres_q[$past(victim)] == '0 && fseg_q == $past(victim))
		else $error("allocation did not retag the lru segment");

	a_lru_perm: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ9
		lru_q[0] != lru_q[1] && lru_q[0] != lru_q[2] && lru_q[0] != lru_q[3]
			&& lru_q[1] != lru_q[2] && lru_q[1] != lru_q[3] && lru_q[2] != lru_q[3])
		else $error("usage stack lost a segment");

	a_hit_mru: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ9
		take |=> lru_q[0] == $past(hit_seg))
		else $error("hit segment not moved to top of stack");

	a_flush_clr: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ13
		flush_i |=> pres_q == '0)
		else $error("flush left a present flag set");

	a_fill_done: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ12
		fill_end && !fkill_q && !flush_i |=> pres_q[$past(fseg_q)][$past(fsub_q)]
			&& state_q == ST_IDLE)
		else $error("completed fill not marked present");

	a_word_out: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ10
		take |=> fetch_valid_o && fetch_word_o == $past(rd_word))
		else $error("hit word not delivered next cycle");

	c_hit: cover property (@(posedge mclk_i) disable iff (!rst_n_i) take);
	c_tag_miss: cover property (@(posedge mclk_i) disable iff (!rst_n_i) miss_go && !tag_hit);
	c_sub_miss: cover property (@(posedge mclk_i) disable iff (!rst_n_i) miss_go && tag_hit);
	c_fill_flush: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state_q == ST_FILL) && flush_i);

endmodule // icf_fetch

// ### tb/icf_mem_model.sv
// behavioural local memory controller answering instruction fills
`timescale 1ns/1ps
module icf_mem_model
	import icf_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              mem_req_i,
	input  wire logic [ADDR_W-1:0] mem_addr_i,
	input  wire logic [1:0]        gap_i,
	output logic                   mem_valid_o,
	output logic [WORD_W-1:0]      mem_data_o
);
	logic [2:0]        cnt_q;
	logic [1:0]        wait_q;
	logic [ADDR_W-1:0] word_addr;

	// word k of the subsegment sits k words above its start
	assign word_addr = mem_addr_i + {cnt_q[1:0], 4'h0};

	// four words in order, gap_i idle cycles before each; data toggles when idle
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q       <= 3'h0;
			wait_q      <= 2'h0;
			mem_valid_o <= 1'b0;
			mem_data_o  <= 16'h0000;
		end else if (!mem_req_i || cnt_q == 3'h4) begin
			mem_valid_o <= 1'b0;
			mem_data_o  <= ~mem_data_o;
			wait_q      <= 2'h0;
			if (!mem_req_i)
				cnt_q <= 3'h0;
		end else if (wait_q < gap_i) begin
			wait_q      <= wait_q + 2'h1;
			mem_valid_o <= 1'b0;
			mem_data_o  <= ~mem_data_o;
		end else begin
			mem_valid_o <= 1'b1;
			mem_data_o  <= word_addr[19:4];
			cnt_q       <= cnt_q + 3'h1;
			wait_q      <= 2'h0;
		end
	end
endmodule // icf_mem_model

// ### tb/icf_fetch_tb.sv
// self-checking bench for the fetch pointer and instruction cache
`timescale 1ns/1ps
module icf_fetch_tb;
	import icf_pkg::*;
	logic              mclk_i = 1'b0;
	logic              rst_n_i = 1'b0;
	logic              fetch_req_i = 1'b0;
	logic              ptr_load_i = 1'b0;
	logic              flush_i = 1'b0;
	logic [ADDR_W-1:0] ptr_load_addr_i = 32'h0000_0000;
	logic              fetch_ready_o, fetch_valid_o, mem_req_o, mem_valid_i;
	logic [WORD_W-1:0] fetch_word_o, mem_data_i;
	logic [ADDR_W-1:0] ptr_o, mem_addr_o, fill_addr;
	logic [1:0]        gap = 2'h0;
	logic              req_prev = 1'b0;
	int                num_errors = 0;
	int                n_compared = 0;
	int                fills = 0;

	icf_fetch icf_fetch_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fetch_req_i(fetch_req_i),
		.fetch_ready_o(fetch_ready_o), .fetch_valid_o(fetch_valid_o),
		.fetch_word_o(fetch_word_o), .ptr_load_i(ptr_load_i),
		.ptr_load_addr_i(ptr_load_addr_i), .instruction_fetch_pointer_o(ptr_o),
		.flush_i(flush_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
		.mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i));
	icf_mem_model icf_mem_model_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .gap_i(gap),
		.mem_valid_o(mem_valid_i), .mem_data_o(mem_data_i));

	always #5 mclk_i = ~mclk_i;

	// count fills by the rising edge of the memory request, remember where each went
	always @(posedge mclk_i) begin
		req_prev <= mem_req_o;
		if (mem_req_o && !req_prev) begin
			fills++;
			fill_addr <= mem_addr_o;
		end
	end

	task chk(input string nm, input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task test_done;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// one take at pointer a; ready is sampled mid-cycle, so no race with the edge
	task take_one(input logic [ADDR_W-1:0] a);
		int i;
		i = 0;
		@(posedge mclk_i);
		fetch_req_i <= 1'b1;
		@(negedge mclk_i);
		while (fetch_ready_o !== 1'b1 && i < 200) begin
			@(negedge mclk_i);
			i++;
		end
		if (i >= 200) begin
			num_errors++;
			test_done;
		end
		chk("valid idle", 32'(fetch_valid_o), 32'h0);
		@(posedge mclk_i);
		fetch_req_i <= 1'b0;
		#1;
		chk("valid", 32'(fetch_valid_o), 32'h1);
		chk("word", 32'(fetch_word_o), 32'(a[19:4]));
		chk("pointer", ptr_o, a + PTR_STEP);
	endtask

	task jump(input logic [ADDR_W-1:0] a);
		@(posedge mclk_i);
		ptr_load_i      <= 1'b1;
		ptr_load_addr_i <= a;
		@(posedge mclk_i);
		ptr_load_i <= 1'b0;
		#1;
		chk("loaded pointer", ptr_o, {a[31:4], 4'h0});
	endtask

	// jump, fetch one word and check how many fills it cost and their address
	task jf(input logic [ADDR_W-1:0] a, input int nf);
		int f0;
		f0 = fills;
		jump(a);
		take_one({a[31:4], 4'h0});
		chk("fills", 32'(fills - f0), 32'(nf));
		if (nf > 0)
			chk("fill address", fill_addr, {a[31:6], 6'h00});
	endtask

	task flush;
		@(posedge mclk_i);
		flush_i <= 1'b1;
		@(posedge mclk_i);
		flush_i <= 1'b0;
		#1;
		chk("ready after flush", 32'(fetch_ready_o), 32'h0);
	endtask

	task s_reset;
		chk("reset pointer", ptr_o, PTR_RESET);
		chk("reset ready", 32'(fetch_ready_o), 32'h0);
		chk("reset mem req", 32'(mem_req_o), 32'h0);
	endtask

	// slow memory, odd load address, two subsegments then a replay that must hit
	task s_seq;
		int k;
		int f0;
		gap = 2'h3;
		f0 = fills;
		jump(32'h0000_100f);
		for (k = 0; k < 8; k++)
			take_one(32'h0000_1000 + 32'(k * 16));
		chk("sequential fills", 32'(fills - f0), 32'h2);
		jump(32'h0000_1000);
		for (k = 0; k < 4; k++)
			take_one(32'h0000_1000 + 32'(k * 16));
		chk("replay fills", 32'(fills - f0), 32'h2);
		gap = 2'h0;
	endtask

	// fill four segments, touch one, then force two replacements
	task s_lru;
		int k;
		flush;
		for (k = 1; k < 5; k++)
			jf(32'(k * 32'h200), 1);
		jf(32'h0000_0200, 0);
		jf(32'h0000_0a00, 1);
		jf(32'h0000_0200, 0);
		jf(32'h0000_0600, 0);
		jf(32'h0000_0800, 0);
		jf(32'h0000_0400, 1);
	endtask

	// after a flush every held line misses, and a kept tag reloads one subsegment
	task s_flush;
		flush;
		jf(32'h0000_0200, 1);
		jf(32'h0000_0240, 1);
		jf(32'h0000_0600, 1);
	endtask

	// a flush in mid-fill kills that fill, so the same subsegment is fetched again
	task s_kill;
		int f0;
		f0 = fills;
		jump(32'h0000_0c00);
		@(posedge mclk_i);
		fetch_req_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		flush_i <= 1'b1;
		@(posedge mclk_i);
		flush_i <= 1'b0;
		take_one(32'h0000_0c00);
		chk("killed fill refetched", 32'(fills - f0), 32'h2);
	endtask

	initial begin
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		#1;
		s_reset;
		s_seq;
		s_lru;
		s_flush;
		s_kill;
		test_done;
	end
endmodule // icf_fetch_tb
